// >>> hws_top.v
// host wake, ready status and general pin block with apb registers
// Operation
// - ready output high after reset until the ctrl ready bit is written 0, low in reset
// - wake input pulled low; rising edge wakes
// - falling wake edge permits sleep
// - wake level accepted after over 500ms stable
// - wake notify output idles high
// - wake source gives one 1s low pulse
// - nine pins, direction and level settable
// - pin input levels readable
// - reset pins to inputs with pull-down
`timescale 1ns/1ps
`default_nettype none
`include "hws_consts.vh"
module hws_top #(
    parameter [31:0] DEBOUNCE_CYC = `HWS_DEBOUNCE_CYC,
    parameter [31:0] PULSE_CYC    = `HWS_PULSE_CYC
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg         ready_state_o,
    input  wire        wake_req_i,
    output reg         wake_req_pd_o,
    output reg         wake_notify_o,
    output reg         awake_o,
    input  wire [8:0]  gp_in_i,
    output reg  [8:0]  gp_out_o,
    output reg  [8:0]  gp_oe_o,
    output reg  [8:0]  gp_pd_o,
    output reg         irq_o
);
    reg        ready_cfg_r;
    reg        wake_src_r;
    reg [8:0]  gp_dir_r;
    reg [8:0]  gp_lvl_r;
    reg [8:0]  gp_s1_r;
    reg [8:0]  gp_s2_r;
    reg        wk_s1_r;
    reg        wk_s2_r;
    reg        awake_r;
    reg        pulse_r;
    reg [31:0] pcnt_r;
    reg [2:0]  irq_st_r;
    reg [2:0]  irq_msk_r;
    reg [2:0]  irq_set;
    reg [2:0]  irq_st_nxt;
    reg [31:0] rdata;
    reg        addr_ok;
    wire       wk_level;
    wire       wk_rise;
    wire       wk_fall;
    wire       apb_acc;
    wire       apb_wr;
    wire       src_evt;
    wire       pulse_end;

    assign apb_acc   = psel_i & penable_i & ~pready_o;
    assign apb_wr    = apb_acc & pwrite_i;
    // one write of the source bit is one wake source
    assign src_evt   = apb_wr & (paddr_i == `HWS_ADDR_CTRL)
                     & pwdata_i[`HWS_CTRL_WAKESRC];
    assign pulse_end = pulse_r & (pcnt_r == PULSE_CYC - 32'd1);

    // two stages before the debouncer; pin comes from another domain
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            wk_s1_r <= 1'b0;
            wk_s2_r <= 1'b0;
            gp_s1_r <= 9'h000;
            gp_s2_r <= 9'h000;
        end else begin
            wk_s1_r <= wake_req_i;
            wk_s2_r <= wk_s1_r;
            gp_s1_r <= gp_in_i;
            gp_s2_r <= gp_s1_r;
        end
    end

    hws_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
    ) u_deb (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .raw_i     (wk_s2_r),
        .level_o   (wk_level),
        .rise_o    (wk_rise),
        .fall_o    (wk_fall)
    );

    // sleep state follows debounced edges only
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            awake_r <= 1'b0;
        end else if (wk_rise) begin
            awake_r <= 1'b1;
        end else if (wk_fall) begin
            awake_r <= 1'b0;
        end
    end

    // notify pulse; a source mid-pulse is absorbed, not restarted
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pulse_r <= 1'b0;
            pcnt_r  <= 32'h0;
        end else if (pulse_r) begin
            if (pulse_end) begin
                pulse_r <= 1'b0;
                pcnt_r  <= 32'h0;
            end else begin
                pcnt_r <= pcnt_r + 32'd1;
            end
        end else if (src_evt) begin
            pulse_r <= 1'b1;
            pcnt_r  <= 32'h0;
        end
    end

    always @* begin
        irq_set = 3'b000;
        irq_set[`HWS_IRQ_WAKE]      = wk_rise;
        irq_set[`HWS_IRQ_SLEEP]     = wk_fall;
        irq_set[`HWS_IRQ_PULSEDONE] = pulse_end;
        irq_st_nxt = irq_st_r;
        if (apb_wr && paddr_i == `HWS_ADDR_IRQST) begin
            irq_st_nxt = irq_st_r & ~pwdata_i[2:0];
        end
        // set wins over a clear in the same cycle
        irq_st_nxt = irq_st_nxt | irq_set;
    end

    always @* begin
        rdata   = 32'h0;
        addr_ok = 1'b1;
        case (paddr_i)
            `HWS_ADDR_CTRL:   rdata = {31'h0, ready_cfg_r};
            `HWS_ADDR_STATUS: rdata = {29'h0, wk_level, pulse_r, awake_r};
            `HWS_ADDR_GPDIR:  rdata = {23'h0, gp_dir_r};
            `HWS_ADDR_GPOUT:  rdata = {23'h0, gp_lvl_r};
            `HWS_ADDR_GPIN:   rdata = {23'h0, gp_s2_r};
            `HWS_ADDR_IRQST:  rdata = {29'h0, irq_st_r};
            `HWS_ADDR_IRQMSK: rdata = {29'h0, irq_msk_r};
            default:          addr_ok = 1'b0;
        endcase
    end

    // apb slave: one wait state, error on unmapped address
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ready_cfg_r <= `HWS_RST_READY;
            gp_dir_r    <= `HWS_RST_GPDIR;
            gp_lvl_r    <= `HWS_RST_GPOUT;
            irq_msk_r   <= `HWS_RST_IRQMSK;
            irq_st_r    <= 3'b000;
            pready_o    <= 1'b0;
            pslverr_o   <= 1'b0;
            prdata_o    <= 32'h0;
        end else begin
            irq_st_r  <= irq_st_nxt;
            pready_o  <= apb_acc;
            pslverr_o <= apb_acc & ~addr_ok;
            prdata_o  <= (apb_acc & ~pwrite_i) ? rdata : 32'h0;
            if (apb_wr) begin
                case (paddr_i)
                    `HWS_ADDR_CTRL:
                        ready_cfg_r <= pwdata_i[`HWS_CTRL_READY];
                    `HWS_ADDR_GPDIR:  gp_dir_r  <= pwdata_i[8:0];
                    `HWS_ADDR_GPOUT:  gp_lvl_r  <= pwdata_i[8:0];
                    `HWS_ADDR_IRQMSK: irq_msk_r <= pwdata_i[2:0];
                    default: ;
                endcase
            end
        end
    end

    // pin outputs, all registered
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ready_state_o <= 1'b0;
            wake_req_pd_o <= 1'b1;
            wake_notify_o <= 1'b1;
            awake_o       <= 1'b0;
            gp_out_o      <= 9'h000;
            gp_oe_o       <= 9'h000;
            gp_pd_o       <= `HWS_RST_GPPD;
            irq_o         <= 1'b0;
        end else begin
            ready_state_o <= ready_cfg_r;
            wake_req_pd_o <= 1'b1;
            wake_notify_o <= ~pulse_r;
            awake_o       <= awake_r;
            gp_out_o      <= gp_lvl_r & gp_dir_r;
            gp_oe_o       <= gp_dir_r;
            gp_pd_o       <= ~gp_dir_r;
            irq_o         <= |(irq_st_r & irq_msk_r);
        end
    end
endmodule // hws_top
`default_nettype wire

// >>> hws_consts.vh
// constants for the host wake and status signalling block
`ifndef HWS_CONSTS_VH
`define HWS_CONSTS_VH
`define HWS_CLK_HZ        50000000
`define HWS_DEBOUNCE_MS   500
`define HWS_PULSE_MS      1000
`define HWS_DEBOUNCE_CYC  (`HWS_CLK_HZ / 1000 * `HWS_DEBOUNCE_MS + 1)
`define HWS_PULSE_CYC     (`HWS_CLK_HZ / 1000 * `HWS_PULSE_MS)
`define HWS_NPINS         9
`define HWS_ADDR_CTRL     12'h000
`define HWS_ADDR_STATUS   12'h004
`define HWS_ADDR_GPDIR    12'h008
`define HWS_ADDR_GPOUT    12'h00C
`define HWS_ADDR_GPIN     12'h010
`define HWS_ADDR_IRQST    12'h014
`define HWS_ADDR_IRQMSK   12'h018
`define HWS_CTRL_READY    0
`define HWS_CTRL_WAKESRC  1
`define HWS_ST_AWAKE      0
`define HWS_ST_PULSE      1
`define HWS_IRQ_WAKE      0
`define HWS_IRQ_SLEEP     1
`define HWS_IRQ_PULSEDONE 2
`define HWS_RST_GPDIR     9'h000
`define HWS_RST_GPOUT     9'h000
`define HWS_RST_READY     1'b1
`define HWS_RST_IRQMSK    3'b000
`define HWS_RST_GPPD      9'h1FF
`endif

// >>> hws_debounce.v
// debouncer: accepts a new level after it stays stable long enough
`timescale 1ns/1ps
`default_nettype none
module hws_debounce #(
    parameter [31:0] STABLE_CYC = 32'd25000001
) (
    input  wire clk_i,
    input  wire sys_rst_i,
    input  wire raw_i,
    output reg  level_o,
    output reg  rise_o,
    output reg  fall_o
);
    reg [31:0] cnt_r;

    // short glitches restart the count and never reach the output
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_r   <= 32'h0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (raw_i == level_o) begin
                cnt_r <= 32'h0;
            end else if (cnt_r >= STABLE_CYC - 32'd1) begin
                cnt_r   <= 32'h0;
                level_o <= raw_i;
                rise_o  <= raw_i;
                fall_o  <= ~raw_i;
            end else begin
                cnt_r <= cnt_r + 32'd1;
            end
        end
    end
endmodule // hws_debounce
`default_nettype wire

// >>> hws_top_assertions.sv
// port checker for the wake, notify and pin behaviour
`timescale 1ns/1ps
`default_nettype none
module hws_chk #(
    parameter [31:0] DEBOUNCE_CYC = 32'd20,
    parameter [31:0] PULSE_CYC    = 32'd10
) (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       ready_state_o,
    input wire logic       wake_req_i,
    input wire logic       wake_req_pd_o,
    input wire logic       wake_notify_o,
    input wire logic       awake_o,
    input wire logic [8:0] gp_oe_o,
    input wire logic [8:0] gp_pd_o
);
    logic [31:0] st_r;
    logic [31:0] lo_r;
    logic        wr_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // pin hold time and notify low time, counted here not in the design
    always_ff @(posedge clk_i) begin
        wr_r <= wake_req_i;
        st_r <= (sys_rst_i || wake_req_i != wr_r) ? 32'h0 : st_r + 32'h1;
        lo_r <= (sys_rst_i || wake_notify_o) ? 32'h0 : lo_r + 32'h1;
    end
    ready_rst_low_a: assert property (
        $past(sys_rst_i) |-> !ready_state_o)
        else $error("ready high right after reset");
    wake_pd_on_a: assert property (wake_req_pd_o)
        else $error("wake pull-down off");
    awake_rise_a: assert property ($rose(awake_o) |-> wake_req_i)
        else $error("awake without high pin");
    awake_fall_a: assert property ($fell(awake_o) |-> !wake_req_i)
        else $error("sleep without low pin");
    awake_held_a: assert property (
        $changed(awake_o) |-> st_r >= DEBOUNCE_CYC)
        else $error("awake changed before debounce");
    notify_idle_a: assert property (
        !wake_notify_o |-> lo_r < PULSE_CYC)
        else $error("notify low too long");
    notify_len_a: assert property (
        $rose(wake_notify_o) |-> lo_r == PULSE_CYC)
        else $error("notify pulse length wrong");
    pin_pd_dir_a: assert property (gp_pd_o == ~gp_oe_o)
        else $error("pull-down not tied to input");
endmodule // hws_chk
bind hws_top hws_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .PULSE_CYC(PULSE_CYC))
    u_hws_chk (.clk_i, .sys_rst_i, .ready_state_o, .wake_req_i,
    .wake_req_pd_o, .wake_notify_o, .awake_o, .gp_oe_o, .gp_pd_o);
`default_nettype wire

// >>> hws_host.sv
// host model: wake pin drive and general pin wire levels
`timescale 1ns/1ps
`default_nettype none
module hws_host (
    input  wire logic       want_i,
    input  wire logic [8:0] drv_en_i,
    input  wire logic [8:0] drv_val_i,
    input  wire logic [8:0] gp_out_i,
    input  wire logic [8:0] gp_oe_i,
    input  wire logic [8:0] gp_pd_i,
    output wire logic       wake_o,
    output wire logic [8:0] gp_o
);
    assign wake_o = want_i;
    // a pin left floating reads high if its pull-down is missing
    assign gp_o = (gp_oe_i & gp_out_i) | (~gp_oe_i & drv_en_i & drv_val_i)
                | (~gp_oe_i & ~drv_en_i & ~gp_pd_i);
endmodule // hws_host
`default_nettype wire

// >>> hws_top_tb.sv
// self-checking bench for the host wake and status block
`timescale 1ns/1ps
`default_nettype none
`include "hws_consts.vh"
module hws_top_tb;
    localparam int DEB = 20;
    localparam int PUL = 10;
    logic        clk_i = 1'h0, sys_rst_i = 1'h1, want = 1'h0, er;
    logic        psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, rd;
    logic [8:0]  den = 9'h0, dval = 9'h0;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, ready_state_o, wake_req_i, irq_o;
    wire         wake_req_pd_o, wake_notify_o, awake_o;
    wire  [8:0]  gp_in_i, gp_out_o, gp_oe_o, gp_pd_o;
    int          n_mismatch = 0, num_checks = 0, n;
    // {write, address, write data, read data, error}
    logic [77:0] rows [7] = '{
        {1'h0, `HWS_ADDR_CTRL, 32'h0, 32'h1, 1'h0},
        {1'h0, `HWS_ADDR_GPDIR, 32'h0, 32'h0, 1'h0},
        {1'h1, `HWS_ADDR_GPDIR, 32'hFFFFFFFF, 32'h1FF, 1'h0},
        {1'h1, `HWS_ADDR_GPOUT, 32'hFFFFFF55, 32'h155, 1'h0},
        {1'h1, `HWS_ADDR_IRQMSK, 32'hFFFFFFFF, 32'h7, 1'h0},
        {1'h1, `HWS_ADDR_STATUS, 32'hFFFFFFFF, 32'h0, 1'h0},
        {1'h1, 12'h01C, 32'h1, 32'h0, 1'h1}};
    hws_top #(.DEBOUNCE_CYC(DEB), .PULSE_CYC(PUL)) u_hws_top (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .ready_state_o(ready_state_o),
        .wake_req_i(wake_req_i), .wake_req_pd_o(wake_req_pd_o),
        .wake_notify_o(wake_notify_o), .awake_o(awake_o),
        .gp_in_i(gp_in_i), .gp_out_o(gp_out_o), .gp_oe_o(gp_oe_o),
        .gp_pd_o(gp_pd_o), .irq_o(irq_o));
    hws_host u_hws_host (.want_i(want), .drv_en_i(den), .drv_val_i(dval),
        .gp_out_i(gp_out_o), .gp_oe_i(gp_oe_o), .gp_pd_i(gp_pd_o),
        .wake_o(wake_req_i), .gp_o(gp_in_i));
    always #10 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'h1;
        @(posedge clk_i);
        while (pready_o !== 1'h1 && k < 20) begin
            k++;
            @(posedge clk_i);
        end
        // a slave that never answers is a failure, not a silent skip
        if (k == 20) n_mismatch++;
        rd = prdata_o;
        er = pslverr_o;
        {psel_i, penable_i} <= 2'h0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        tick(3);
        chk(ready_state_o, 0);
        chk({wake_notify_o, wake_req_pd_o}, 2'h3);
        chk({gp_oe_o, gp_pd_o}, 18'h001FF);
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        tick(3);
        chk(ready_state_o, 1);
        foreach (rows[i]) begin
            if (rows[i][77]) apb(1'h1, rows[i][76:65], rows[i][64:33]);
            apb(1'h0, rows[i][76:65], 32'h0);
            chk(rd, rows[i][32:1]);
            chk(er, rows[i][0]);
        end
        tick(3);
        chk({gp_oe_o, gp_out_o, gp_pd_o}, 27'h7FEAA00);
        apb(1'h0, `HWS_ADDR_GPIN, 32'h0);
        chk(rd, 32'h155);
        {den, dval} <= {9'h0FF, 9'h0A5};
        apb(1'h1, `HWS_ADDR_GPDIR, 32'h0);
        tick(3);
        apb(1'h0, `HWS_ADDR_GPIN, 32'h0);
        chk(rd, 32'h0A5);
        $display("register and pin tests done");
        @(posedge clk_i) want <= 1'h1;
        tick(DEB + 8);
        apb(1'h0, `HWS_ADDR_IRQST, 32'h0);
        chk({awake_o, irq_o, rd[29:0]}, 32'hC0000001);
        apb(1'h0, `HWS_ADDR_STATUS, 32'h0);
        chk(rd, 32'h5);
        apb(1'h1, `HWS_ADDR_IRQST, 32'h1);
        @(posedge clk_i) want <= 1'h0;
        tick(DEB / 2);
        @(posedge clk_i) want <= 1'h1;
        tick(DEB + 8);
        chk({awake_o, irq_o}, 2'h2);
        @(posedge clk_i) want <= 1'h0;
        tick(DEB + 8);
        apb(1'h0, `HWS_ADDR_IRQST, 32'h0);
        chk({awake_o, rd[30:0]}, 32'h2);
        apb(1'h1, `HWS_ADDR_IRQST, 32'h7);
        $display("wake tests done");
        n = 0;
        fork
            repeat (30) @(posedge clk_i) n += (wake_notify_o === 1'h0);
            begin
                apb(1'h1, `HWS_ADDR_CTRL, 32'h3);
                apb(1'h1, `HWS_ADDR_CTRL, 32'h3);
            end
        join
        chk(n, PUL);
        chk({wake_notify_o, irq_o}, 2'h3);
        apb(1'h1, `HWS_ADDR_IRQMSK, 32'h0);
        tick(2);
        chk(irq_o, 0);
        $display("notify tests done");
        apb(1'h1, `HWS_ADDR_GPDIR, 32'h1FF);
        apb(1'h1, `HWS_ADDR_CTRL, 32'h0);
        tick(2);
        chk({ready_state_o, gp_oe_o}, 10'h1FF);
        @(posedge clk_i) sys_rst_i <= 1'h1;
        tick(2);
        chk({ready_state_o, gp_oe_o, gp_pd_o}, 19'h001FF);
        @(posedge clk_i) sys_rst_i <= 1'h0;
        tick(2);
        chk(ready_state_o, 1);
        $display("reset tests done");
        test_done;
    end
    initial begin
        #(20 * 3000);
        n_mismatch++;
        test_done;
    end
endmodule // hws_top_tb
`default_nettype wire
